// [logic/telegram_slave.sv]
/*
 Character receiver, character transmitter and the drive-side telegram
 slave. Assumes bus_level reaches the slave asynchronously and that the
 user side buffers data bytes until the telegram is declared good.
*/
`timescale 1ns/10ps
module char_rx import serial_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [15:0] div_i,
   input wire logic line_i,
   output logic [7:0] data_o,
   output logic valid_o,
   output logic perr_o,
   output logic ferr_o,
   output logic busy_o
);
   logic [15:0] cnt;
   logic [3:0] idx;
   logic [10:0] sh;
   wire [10:0] next_sh = {line_i, sh[10:1]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         cnt <= 16'h0000;
         idx <= 4'h0;
         sh <= 11'h000;
         valid_o <= 1'b0;
         data_o <= 8'h00;
         perr_o <= 1'b0;
         ferr_o <= 1'b0;
      end else if (ce_i) begin
         valid_o <= 1'b0;
         if (!busy_o) begin
            if (!line_i) begin
               busy_o <= 1'b1;
               cnt <= div_i >> 1;
               idx <= 4'h0;
            end
         end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
         end else if (idx == 4'h0 && line_i) begin
            busy_o <= 1'b0; // Glitch, not a start bit
         end else begin
            cnt <= div_i - 16'h0001;
            sh <= next_sh;
            idx <= idx + 4'h1;
            if (idx == STOP_IDX) begin
               busy_o <= 1'b0;
               valid_o <= 1'b1;
               data_o <= next_sh[8:1];
               perr_o <= ^next_sh[9:1];
               ferr_o <= !line_i;
            end
         end
      end
   end
endmodule

module char_tx import serial_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [15:0] div_i,
   input wire logic start_i,
   input wire logic [7:0] data_i,
   output logic line_o,
   output logic busy_o,
   output logic done_o
);
   logic [15:0] cnt;
   logic [3:0] idx;
   logic [10:0] sh;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_o <= 1'b1;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         cnt <= 16'h0000;
         idx <= 4'h0;
         sh <= 11'h7FF;
      end else if (ce_i) begin
         done_o <= 1'b0;
         if (!busy_o) begin
            if (start_i) begin
               busy_o <= 1'b1;
               sh <= frame_char(data_i);
               line_o <= 1'b0;
               cnt <= div_i - 16'h0001;
               idx <= 4'h0;
            end
         end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
         end else if (idx == STOP_IDX) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
         end else begin
            line_o <= sh[1];
            sh <= {1'b1, sh[10:1]};
            idx <= idx + 4'h1;
            cnt <= div_i - 16'h0001;
         end
      end
   end
endmodule

module telegram_slave import serial_pkg::*; #(
   parameter logic [31:0] RESP_MAX = 32'(RESP_MAX_CYC)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [15:0] bit_div_i,
   input wire logic [6:0] own_addr_i,
   serial_link_if.slave link,
   output logic [7:0] rx_data_o,
   output logic rx_data_valid_o,
   output logic tel_ok_o,
   output logic tel_bcast_o,
   output logic tel_err_o,
   input wire logic rep_ready_i,
   input wire logic [7:0] rep_len_i,
   input wire logic [7:0] rep_data_i,
   output logic rep_next_o,
   output logic rep_done_o,
   output logic rep_lost_o
);
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_LEN = 6'h02,
      S_ADDR = 6'h04,
      S_BODY = 6'h08,
      S_WAIT = 6'h10,
      S_SEND = 6'h20
   } slave_state_t;
   slave_state_t state;
   logic sync1, sync2, armed, pend, tx_go;
   logic [7:0] rx_byte, remain, addr, running_checksum, tchk, txn, tx_byte;
   logic rx_valid, rx_perr, rx_ferr, rx_busy, tx_busy, tx_done;
   logic [31:0] gap_cnt, tel_cnt, tel_lim, nominal;

   char_rx rx (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .div_i(bit_div_i), .line_i(sync2), .data_o(rx_byte),
      .valid_o(rx_valid), .perr_o(rx_perr), .ferr_o(rx_ferr),
      .busy_o(rx_busy));
   char_tx tx (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .div_i(bit_div_i), .start_i(tx_go), .data_i(tx_byte),
      .line_o(link.slave_line), .busy_o(tx_busy), .done_o(tx_done));

   wire [31:0] gap_lim = char_cycles(GAP_CHARS, bit_div_i);
   wire gap_ok = gap_cnt > gap_lim;
   wire byte_bad = rx_perr | rx_ferr;
   wire bcast = is_bcast(addr);
   wire for_me = is_own(addr, own_addr_i) && !bcast;
   wire in_tel = (state == S_LEN) || (state == S_ADDR) || (state == S_BODY);
   // The total limit is only known once the length byte is in
   wire timed_out = in_tel && (gap_ok ||
                    (state != S_LEN && tel_cnt > tel_lim));
   wire [31:0] next_nominal = char_cycles(9'(rx_byte) + FRAME_OVERHEAD,
                                          bit_div_i);
   wire [7:0] rep_total = rep_len_i + SEND_OVERHEAD;
   wire cur_is_data = txn >= POS_DATA && txn < rep_total - 8'h01;
   wire [7:0] cur_byte = txn == POS_START ? START_CHAR :
                         txn == POS_LEN ? rep_len_i + LEN_OVERHEAD :
                         txn == POS_ADDR ? addr :
                         cur_is_data ? rep_data_i : tchk;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         gap_cnt <= 32'h00000000;
         tel_cnt <= 32'h00000000;
         armed <= 1'b0;
      end else if (ce_i) begin
         sync1 <= link.bus_level;
         sync2 <= sync1;
         if (rx_busy) begin
            gap_cnt <= 32'h00000000;
         end else if (gap_cnt != 32'hFFFFFFFF) begin
            gap_cnt <= gap_cnt + 32'h00000001;
         end
         tel_cnt <= in_tel ? tel_cnt + 32'h00000001 : 32'h00000000;
         // Any character since the last long gap disarms the start hunt
         if (gap_ok) begin
            armed <= 1'b1;
         end else if (rx_valid) begin
            armed <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         remain <= 8'h00;
         addr <= 8'h00;
         running_checksum <= 8'h00;
         tel_lim <= 32'h00000000;
         nominal <= 32'h00000000;
         txn <= 8'h00;
         tchk <= 8'h00;
         pend <= 1'b0;
         tx_go <= 1'b0;
         tx_byte <= 8'h00;
         link.slave_oe <= 1'b0;
         rx_data_o <= 8'h00;
         rx_data_valid_o <= 1'b0;
         tel_ok_o <= 1'b0;
         tel_bcast_o <= 1'b0;
         tel_err_o <= 1'b0;
         rep_next_o <= 1'b0;
         rep_done_o <= 1'b0;
         rep_lost_o <= 1'b0;
      end else if (ce_i) begin
         tx_go <= 1'b0;
         rx_data_valid_o <= 1'b0;
         tel_ok_o <= 1'b0;
         tel_err_o <= 1'b0;
         rep_next_o <= 1'b0;
         rep_done_o <= 1'b0;
         rep_lost_o <= 1'b0;
         case (state)
            S_IDLE: begin
               if (rx_valid && !byte_bad && armed &&
                   rx_byte == START_CHAR) begin
                  state <= S_LEN;
                  running_checksum <= START_CHAR;
               end
            end
            S_LEN, S_ADDR, S_BODY: begin
               if (timed_out || (rx_valid && byte_bad) ||
                   (rx_valid && state == S_LEN &&
                    rx_byte < LEN_OVERHEAD)) begin
                  state <= S_IDLE;
                  tel_err_o <= 1'b1;
               end else if (rx_valid) begin
                  running_checksum <= running_checksum ^ rx_byte;
                  remain <= remain - 8'h01;
                  if (state == S_LEN) begin
                     remain <= rx_byte;
                     nominal <= next_nominal;
                     tel_lim <= next_nominal + (next_nominal >> 1);
                     state <= S_ADDR;
                  end else if (state == S_ADDR) begin
                     addr <= rx_byte;
                     state <= S_BODY;
                  end else if (remain == 8'h01) begin
                     state <= S_IDLE;
                     if (running_checksum != rx_byte) begin
                        tel_err_o <= 1'b1;
                     end else begin
                        tel_ok_o <= for_me | bcast;
                        tel_bcast_o <= bcast;
                        if (for_me) begin
                           state <= S_WAIT;
                        end
                     end
                  end else if (for_me | bcast) begin
                     rx_data_o <= rx_byte;
                     rx_data_valid_o <= 1'b1;
                  end
               end
            end
            S_WAIT: begin
               if (gap_cnt >= RESP_MAX) begin
                  state <= S_IDLE;
                  rep_lost_o <= 1'b1;
               end else if (rep_ready_i && gap_cnt >= gap_lim) begin
                  state <= S_SEND;
                  txn <= POS_START;
                  tchk <= 8'h00;
                  pend <= 1'b1;
                  link.slave_oe <= 1'b1;
               end
            end
            S_SEND: begin
               if (pend && !tx_busy) begin
                  tx_go <= 1'b1;
                  tx_byte <= cur_byte;
                  tchk <= tchk ^ cur_byte;
                  txn <= txn + 8'h01;
                  pend <= 1'b0;
                  rep_next_o <= cur_is_data;
               end else if (tx_done) begin
                  if (txn == rep_total) begin
                     state <= S_IDLE;
                     link.slave_oe <= 1'b0;
                     rep_done_o <= 1'b1;
                  end else begin
                     pend <= 1'b1;
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

// [logic/serial_pkg.sv]
/*
 Shared constants, address decode and timing helpers for the serial
 telegram link. Assumes a single 250 MHz system clock on both ends.
*/
package serial_pkg;
   localparam logic [7:0] START_CHAR = 8'h02;
   localparam logic [3:0] STOP_IDX = 4'hA;
   localparam int BITS_PER_CHAR = 11;
   localparam logic [8:0] GAP_CHARS = 9'h002;
   localparam logic [7:0] LEN_OVERHEAD = 8'h02;
   localparam logic [8:0] FRAME_OVERHEAD = 9'h002;
   localparam logic [7:0] POS_START = 8'h00;
   localparam logic [7:0] POS_LEN = 8'h01;
   localparam logic [7:0] POS_ADDR = 8'h02;
   localparam logic [7:0] POS_DATA = 8'h03;
   localparam logic [7:0] SEND_OVERHEAD = 8'h04;
   localparam int ADDR_LONG_BIT = 7;
   localparam int ADDR_BCAST_BIT = 5;
   localparam int CLK_MHZ = 250;
   localparam int BAUD_RST = 9600;
   localparam logic [15:0] DIV_RST = 16'(CLK_MHZ * 1000000 / BAUD_RST);
   localparam int RESP_MAX_US = 20000;
   localparam int REPLY_WAIT_US = 50000;
   localparam int RESP_MAX_CYC = RESP_MAX_US * CLK_MHZ;
   localparam int REPLY_WAIT_CYC = REPLY_WAIT_US * CLK_MHZ;
   // Controller register map (byte addresses)
   localparam logic [7:0] RA_DIV = 8'h00;
   localparam logic [7:0] RA_CMD = 8'h04;
   localparam logic [7:0] RA_TXD = 8'h08;
   localparam logic [7:0] RA_RXD = 8'h0C;
   localparam logic [7:0] RA_STAT = 8'h10;
   localparam logic [7:0] RA_MASK = 8'h14;
   localparam int CMD_GO_BIT = 16;
   localparam int BUSY_BIT = 31;
   localparam int ST_OK = 0;
   localparam int ST_ERR = 1;
   localparam int ST_TMO = 2;
   localparam int ST_SENT = 3;
   localparam int ST_W = 4;
   localparam int RXCNT_LSB = 8;

   function automatic logic [10:0] frame_char(input logic [7:0] d);
      return {1'b1, ^d, d, 1'b0};
   endfunction

   function automatic logic [31:0] char_cycles(input logic [8:0] n,
                                               input logic [15:0] div);
      return 32'(n) * 32'(BITS_PER_CHAR) * 32'(div);
   endfunction

   function automatic logic is_bcast(input logic [7:0] a);
      return a[ADDR_LONG_BIT] ? (a[6:0] == 7'h00) : a[ADDR_BCAST_BIT];
   endfunction

   function automatic logic is_own(input logic [7:0] a,
                                   input logic [6:0] own);
      return a[ADDR_LONG_BIT] ? (a[6:0] == own) :
             (!a[ADDR_BCAST_BIT] && a[4:0] == own[4:0]);
   endfunction

   function automatic logic [31:0] merge32(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            old[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return old;
   endfunction
endpackage

// [logic/serial_link_if.sv]
/*
 Two-wire-pair RS-485 style half duplex bus between one master and one
 slave. Assumes at most one end enables its driver at a time.
*/
`timescale 1ns/10ps
interface serial_link_if;
   logic master_line;
   logic master_oe;
   logic slave_line;
   logic slave_oe;
   logic bus_level;
   // Idle bus is biased to mark level
   assign bus_level = master_oe ? master_line :
                      (slave_oe ? slave_line : 1'b1);
   modport master(output master_line, output master_oe, input bus_level);
   modport slave(output slave_line, output slave_oe, input bus_level);
endinterface

// [logic/telegram_master.sv]
/*
 Bus master controller: sends telegrams ordered over classic Wishbone
 and collects the reply. Assumes the slave end sits on the same link
 interface and that software fills the send buffer before ordering.
*/
`timescale 1ns/10ps
module telegram_master import serial_pkg::*; #(
   parameter int DEPTH = 32,
   parameter logic [31:0] REPLY_WAIT = 32'(REPLY_WAIT_CYC)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic irq_o,
   serial_link_if.master link
);
   localparam int PW = $clog2(DEPTH);
   typedef enum logic [5:0] {
      M_IDLE = 6'h01,
      M_SEND = 6'h02,
      M_WAIT = 6'h04,
      M_LEN = 6'h08,
      M_ADDR = 6'h10,
      M_BODY = 6'h20
   } master_state_t;
   master_state_t state;
   logic [15:0] div;
   logic [15:0] cmd;
   logic [ST_W-1:0] stat, mask, set_st;
   logic [7:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic [PW-1:0] wptr, rptr;
   logic [7:0] rx_cnt, remain, chk, tchk, txn, tx_byte, rx_byte;
   logic go_pend, sync1, sync2, pend, tx_go, tx_busy, tx_done;
   logic rx_valid, rx_perr, rx_ferr, rx_busy;
   logic [31:0] gap_cnt;

   char_rx rx (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .div_i(div),
      .line_i(sync2), .data_o(rx_byte), .valid_o(rx_valid),
      .perr_o(rx_perr), .ferr_o(rx_ferr), .busy_o(rx_busy));
   char_tx tx (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .div_i(div),
      .start_i(tx_go), .data_i(tx_byte), .line_o(link.master_line),
      .busy_o(tx_busy), .done_o(tx_done));

   wire req = cyc_i && stb_i && !ack_o;
   wire wr = req && we_i;
   wire rd = req && !we_i;
   wire go_wr = wr && adr_i == RA_CMD && sel_i[2] && dat_i[CMD_GO_BIT];
   wire [ST_W-1:0] clr_st = (wr && adr_i == RA_STAT && sel_i[0]) ?
                            dat_i[ST_W-1:0] : '0;
   wire busy = go_pend || state != M_IDLE;
   wire [7:0] dst = cmd[7:0];
   wire [7:0] n_data = cmd[15:8];
   wire [31:0] gap_lim = char_cycles(GAP_CHARS, div);
   wire bad = rx_perr | rx_ferr;
   wire [7:0] total = n_data + SEND_OVERHEAD;
   wire is_data = txn >= POS_DATA && txn < total - 8'h01;
   wire [7:0] cur = txn == POS_START ? START_CHAR :
                    txn == POS_LEN ? n_data + LEN_OVERHEAD :
                    txn == POS_ADDR ? dst :
                    is_data ? tx_mem[PW'(txn - POS_DATA)] : tchk;
   // Byte-lane merges are named so that only their low bits are kept
   wire [31:0] div_wr = merge32({16'h0000, div}, dat_i, sel_i);
   wire [31:0] cmd_wr = merge32({16'h0000, cmd}, dat_i, sel_i);
   wire [31:0] mask_wr = merge32({28'h0000000, mask}, dat_i, sel_i);
   wire [31:0] rd_data =
      adr_i == RA_DIV ? {16'h0000, div} :
      adr_i == RA_CMD ? {busy, 15'h0000, cmd} :
      adr_i == RA_RXD ? {24'h000000, rx_mem[rptr]} :
      adr_i == RA_STAT ? {16'h0000, rx_cnt, 4'h0, stat} :
      adr_i == RA_MASK ? {28'h0000000, mask} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         div <= DIV_RST;
         cmd <= 16'h0000;
         mask <= '0;
         wptr <= '0;
         rptr <= '0;
         irq_o <= 1'b0;
      end else if (ce_i) begin
         ack_o <= req;
         irq_o <= |(stat & mask);
         if (rd) begin
            dat_o <= rd_data;
            if (adr_i == RA_RXD) begin
               rptr <= rptr + 1'b1;
            end
         end
         if (wr && adr_i == RA_DIV) begin
            div <= div_wr[15:0];
         end
         if (wr && adr_i == RA_CMD) begin
            cmd <= cmd_wr[15:0];
         end
         if (wr && adr_i == RA_MASK) begin
            mask <= mask_wr[ST_W-1:0];
         end
         if (wr && adr_i == RA_TXD && sel_i[0]) begin
            tx_mem[wptr] <= dat_i[7:0];
            wptr <= wptr + 1'b1;
         end
         if (go_wr) begin
            wptr <= '0;
            rptr <= '0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         gap_cnt <= 32'h00000000;
         stat <= '0;
      end else if (ce_i) begin
         sync1 <= link.bus_level;
         sync2 <= sync1;
         if (rx_busy) begin
            gap_cnt <= 32'h00000000;
         end else if (gap_cnt != 32'hFFFFFFFF) begin
            gap_cnt <= gap_cnt + 32'h00000001;
         end
         // An event in the clearing cycle survives
         stat <= (stat & ~clr_st) | set_st;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= M_IDLE;
         go_pend <= 1'b0;
         set_st <= '0;
         pend <= 1'b0;
         tx_go <= 1'b0;
         tx_byte <= 8'h00;
         txn <= 8'h00;
         tchk <= 8'h00;
         chk <= 8'h00;
         remain <= 8'h00;
         rx_cnt <= 8'h00;
         link.master_oe <= 1'b0;
      end else if (ce_i) begin
         set_st <= '0;
         tx_go <= 1'b0;
         if (go_wr) begin
            go_pend <= 1'b1;
         end
         case (state)
            M_IDLE: begin
               if (go_pend && gap_cnt >= gap_lim) begin
                  state <= M_SEND;
                  go_pend <= 1'b0;
                  txn <= POS_START;
                  tchk <= 8'h00;
                  pend <= 1'b1;
                  rx_cnt <= 8'h00;
                  link.master_oe <= 1'b1;
               end
            end
            M_SEND: begin
               if (pend && !tx_busy) begin
                  tx_go <= 1'b1;
                  tx_byte <= cur;
                  tchk <= tchk ^ cur;
                  txn <= txn + 8'h01;
                  pend <= 1'b0;
               end else if (tx_done) begin
                  if (txn != total) begin
                     pend <= 1'b1;
                  end else begin
                     link.master_oe <= 1'b0;
                     state <= is_bcast(dst) ? M_IDLE : M_WAIT;
                     set_st[ST_SENT] <= is_bcast(dst);
                  end
               end
            end
            M_WAIT: begin
               if (gap_cnt >= REPLY_WAIT) begin
                  state <= M_IDLE;
                  set_st[ST_TMO] <= 1'b1;
               end else if (rx_valid && !bad && rx_byte == START_CHAR) begin
                  state <= M_LEN;
                  chk <= START_CHAR;
               end
            end
            M_LEN, M_ADDR, M_BODY: begin
               if (gap_cnt > gap_lim || (rx_valid && (bad ||
                   (state == M_LEN && rx_byte < LEN_OVERHEAD) ||
                   (state == M_ADDR && rx_byte != dst)))) begin
                  state <= M_IDLE;
                  set_st[ST_ERR] <= 1'b1;
               end else if (rx_valid) begin
                  chk <= chk ^ rx_byte;
                  remain <= remain - 8'h01;
                  if (state == M_LEN) begin
                     remain <= rx_byte;
                     state <= M_ADDR;
                  end else if (state == M_ADDR) begin
                     state <= M_BODY;
                  end else if (remain == 8'h01) begin
                     state <= M_IDLE;
                     set_st[ST_OK] <= chk == rx_byte;
                     set_st[ST_ERR] <= chk != rx_byte;
                  end else if (rx_cnt < 8'(DEPTH)) begin
                     rx_mem[PW'(rx_cnt)] <= rx_byte;
                     rx_cnt <= rx_cnt + 8'h01;
                  end
               end
            end
            default: state <= M_IDLE;
         endcase
      end
   end
endmodule

// [verif/telegram_link_properties.sv]
/* Link checker for the telegram bus.
   Assumes both ends run at DIV clocks per bit. */
`timescale 1ns/10ps
module telegram_link_properties #(parameter int DIV = 8) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic master_line,
   input wire logic master_oe,
   input wire logic slave_line,
   input wire logic slave_oe,
   input wire logic bus_level
);
   int idle;
   int low;
   logic by_slave;
   always_ff @(posedge clk_i) begin
      idle <= (rst_i || master_oe || slave_oe) ? 0 : idle + 1;
      low <= (rst_i || bus_level) ? 0 : low + 1;
      by_slave <= rst_i ? 1'b0 : (slave_oe | (by_slave & ~master_oe));
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence zero_bit;
      (!slave_line) [*8];
   endsequence
   chk_no_clash: assert property (!(master_oe && slave_oe))
      else $error("both ends drive the bus");
   chk_reply_gap: assert property ($rose(slave_oe) |-> idle >= 22*DIV-2)
      else $error("reply started too early");
   chk_poll_gap: assert property
      ($rose(master_oe) && by_slave |-> idle >= 22*DIV-2)
      else $error("poll too soon after reply");
   chk_bit_len: assert property ($fell(slave_line) && slave_oe |-> zero_bit)
      else $error("short low bit");
   chk_low_run: assert property (low <= 10*DIV)
      else $error("line low too long");
   chk_mark_first: assert property ($rose(master_oe) |-> master_line)
      else $error("driver enabled off mark");
   chk_sstop_last: assert property ($fell(slave_oe) |-> $past(slave_line))
      else $error("reply ends without stop");
   chk_mstop_last: assert property ($fell(master_oe) |-> $past(master_line))
      else $error("poll ends without stop");
endmodule

// [verif/drive_serial_telegram_slave_tb_top.sv]
/* Bench: controller and drive slave joined by the link.
   Assumes the register map of the controller. */
`timescale 1ns/10ps
module drive_serial_telegram_slave_tb_top import serial_pkg::*;;
   localparam int DIV = 8;
   localparam logic [31:0] WT = 32'(30 * 22 * DIV);
   // Row: address, reply ready, slave hit, expected status
   localparam logic [25:0] ROWS[7] = '{
      {8'h45, 2'b11, 16'h0401}, {8'h85, 2'b11, 16'h0401},
      {8'h3F, 2'b11, 16'h0008}, {8'h80, 2'b11, 16'h0008},
      {8'h06, 2'b10, 16'h0004}, {8'hC5, 2'b10, 16'h0004},
      {8'h05, 2'b01, 16'h0004}};
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rdy = 1;
   logic [7:0] adr = 0, ridx = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic ack, irq, rxv, tok, tbc, rnext, rdone, lost;
   logic [7:0] rxd;
   int n_errors = 0, checks_done = 0, nok = 0, nrx = 0, nrep = 0;
   int nsum = 0, nlost = 0;
   serial_link_if link();
   always #2 clk_i = ~clk_i;
   telegram_master #(.REPLY_WAIT(2 * WT)) telegram_master_inst (.clk_i,
      .rst_i, .ce_i(1'b1), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
      .we_i(we), .sel_i(4'hF), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
      .irq_o(irq), .link(link.master));
   telegram_slave #(.RESP_MAX(WT)) telegram_slave_inst (.clk_i, .rst_i,
      .ce_i(1'b1), .bit_div_i(16'(DIV)), .own_addr_i(7'h05),
      .link(link.slave), .rx_data_o(rxd), .rx_data_valid_o(rxv),
      .tel_ok_o(tok), .tel_bcast_o(tbc), .tel_err_o(), .rep_ready_i(rdy),
      .rep_len_i(8'h04), .rep_data_i(8'hA0 + ridx), .rep_next_o(rnext),
      .rep_done_o(rdone), .rep_lost_o(lost));
   telegram_link_properties #(.DIV(DIV)) telegram_link_properties_inst (
      .clk_i, .rst_i, .master_line(link.master_line),
      .master_oe(link.master_oe), .slave_line(link.slave_line),
      .slave_oe(link.slave_oe), .bus_level(link.bus_level));
   always @(posedge clk_i) begin
      ridx <= (rst_i || rdone) ? 8'h00 : ridx + 8'(rnext);
      nok <= nok + int'(tok);
      nrx <= nrx + int'(rxv);
      nrep <= nrep + int'(rdone);
      nsum <= nsum + (rxv ? int'(rxd) : 0);
      nlost <= nlost + int'(lost);
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input int d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= 32'(d);
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic run_row(input logic [25:0] r, input logic ie);
      int k0[5];
      k0 = '{nok, nrx, nrep, nsum, nlost};
      rdy <= r[17];
      for (int i = 0; i < 4; i++) wb(RA_TXD, 1, 16 + i);
      wb(RA_CMD, 1, {15'h0, 1'b1, 8'h04, r[25:18]});
      do wb(RA_STAT, 0, 0); while (q[3:0] == 4'h0);
      cmp(q, 32'(r[15:0]));
      cmp(32'(irq), 32'(ie));
      for (int i = 0; i < 4; i++) begin
         wb(RA_RXD, 0, 0);
         if (r[0]) cmp(32'(q[7:0]), 32'(8'hA0 + i));
      end
      wb(RA_STAT, 1, 15);
      cmp(32'(nok - k0[0]), 32'(r[16]));
      cmp(32'(nrx - k0[1]), r[16] ? 32'h4 : 32'h0);
      cmp(32'(nrep - k0[2]), 32'(r[17] & r[0]));
      cmp(32'(nsum - k0[3]), r[16] ? 32'h46 : 32'h0);
      cmp(32'(nlost - k0[4]), 32'(r[16] & !r[17]));
      if (r[16]) cmp(32'(tbc), 32'(r[3]));
      repeat (2) @(posedge clk_i);
      cmp(32'(irq), 32'h0);
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      wb(RA_DIV, 0, 0);
      cmp(q, 32'(DIV_RST));
      wb(8'h18, 0, 0);
      cmp(q, 32'h0);
      wb(RA_DIV, 1, DIV);
      wb(RA_MASK, 1, 15);
      foreach (ROWS[i]) run_row(ROWS[i], 1'b1);
      wb(RA_MASK, 1, 0);
      run_row(ROWS[1], 1'b0);
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge clk_i);
      n_errors++;
      report_and_stop();
   end
endmodule
